// ==== rtl/pfm_top.sv ====
// Purpose: Port A pin function multiplexer, drive level and capture input routing
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   Pin inputs pass two flops; pin outputs follow the registers directly
// Notes on behaviour
// R1 - Port G nibble drive from bits 5, 4
// R2 - Port F nibble drive from bits 3, 2
// R3 - Port E low nibble drive from bit 0
// R4 - Drive bits 7, 6, 1 read zero
// R5 - Unused function bits always read zero
// R6 - PA3: I/O, serial clock, comparator 0 negative
// R7 - PA2: I/O, serial data in, comparator 0 positive
// R8 - PA1: I/O, serial data out, comparator 0 output
// R9 - PA6: I/O with timer clock, comparator 1 negative
// R10 - PA5: I/O with capture, timer output, comparator
// R11 - PA4: capture, select, timer out, comparator out
// R12 - Route bits pick timer capture pin source
// R13 - Software pairs timer output with capture route
// R14 - Software keeps interrupt pins at plain I/O
// R15 - Software selects pin before enabling peripheral
// R16 - Shared digital inputs need pin set input
// R17 - Software disables peripheral before pin change
// R18 - Selection changes act the cycle after write
// R19 - All selection and drive bits reset zero
`timescale 1ns/1ps
module pfm_top #(
    parameter bit HAS_PORT_F = 1'b1
) (
    // Bus clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Port A pins
    input  wire logic [7:0]  pa_in,
    output logic [7:0]       pa_out,
    output logic [7:0]       pa_oe,
    output logic [7:0]       pa_ana_en,
    // Port A general purpose I/O logic
    input  wire logic [7:0]  gpio_pa_out,
    input  wire logic [7:0]  gpio_pa_oe,
    output logic [7:0]       gpio_pa_in,
    // Serial interface
    input  wire logic        serial_clock_alt_out,
    input  wire logic        serial_clock_alt_oe,
    output logic             serial_clock_alt_in,
    output logic             serial_din_alt,
    input  wire logic        serial_dout_alt,
    input  wire logic        serial_select_alt_out,
    input  wire logic        serial_select_alt_oe,
    output logic             serial_select_alt_in,
    // Timers
    input  wire logic        std_timer_output,
    input  wire logic        periodic_timer0_output,
    output logic             std_timer_clock_in,
    output logic [3:0]       timer_capture_in,
    input  wire logic [3:0]  cap_dflt_pin_in,
    input  wire logic [3:0]  cap_alt_pin_in,
    // Comparators
    input  wire logic        comp0_out,
    input  wire logic        comp1_out,
    // Drive level selects
    output logic             portg_upper_drive_bit,
    output logic             portg_lower_drive_bit,
    output logic             portf_upper_drive_bit,
    output logic             portf_lower_drive_bit,
    output logic             porte_low_drive_bit
);

    localparam logic [7:0] DRIVE_MASK = HAS_PORT_F ? pfm_pkg::MASK_DRIVE_FULL
                                                   : pfm_pkg::MASK_DRIVE_SMALL;

    pfm_sel_if sel ();

    logic [7:0]  drive_reg;
    logic [7:0]  drive_next;
    logic [7:0]  func_lo_reg;
    logic [7:0]  func_lo_next;
    logic [7:0]  func_hi_reg;
    logic [7:0]  func_hi_next;
    logic [7:0]  route_reg;
    logic [7:0]  route_next;
    logic        wr_pend_reg;
    logic [11:0] addr_reg;
    logic [31:0] hrdata_reg;
    logic        accept;
    logic [7:0]  pa_meta_reg;
    logic [7:0]  pa_sync_reg;
    logic [3:0]  capd_meta_reg;
    logic [3:0]  capd_sync_reg;
    logic [3:0]  capa_meta_reg;
    logic [3:0]  capa_sync_reg;
    logic [7:0]  pa_din;
    logic [3:0]  cap_dflt;

    function automatic logic wr_hit(input logic pend, input logic [11:0] a,
                                    input logic [11:0] off);
        return pend && (a[11:2] == off[11:2]);
    endfunction : wr_hit

    // Bus address phase
    assign accept    = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 12'h000;
        end else if (hready) begin
            wr_pend_reg <= accept && hwrite;
            if (accept) begin
                addr_reg <= haddr[11:0];
            end
        end
    end

    // Next values, write data masked to implemented bits
    always_comb begin
        drive_next   = drive_reg;
        func_lo_next = func_lo_reg;
        func_hi_next = func_hi_reg;
        route_next   = route_reg;
        if (wr_hit(wr_pend_reg, addr_reg, pfm_pkg::OFF_DRIVE)) begin
            drive_next = hwdata[7:0] & DRIVE_MASK;                          // R4
        end
        if (wr_hit(wr_pend_reg, addr_reg, pfm_pkg::OFF_FUNC_LO)) begin
            func_lo_next = hwdata[7:0] & pfm_pkg::MASK_FUNC_LO;             // R5
        end
        if (wr_hit(wr_pend_reg, addr_reg, pfm_pkg::OFF_FUNC_HI)) begin
            func_hi_next = hwdata[7:0] & pfm_pkg::MASK_FUNC_HI;             // R5
        end
        if (wr_hit(wr_pend_reg, addr_reg, pfm_pkg::OFF_IN_ROUTE)) begin
            route_next = hwdata[7:0] & pfm_pkg::MASK_IN_ROUTE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_reg <= pfm_pkg::RST_DRIVE;                                 // R19
        end else begin
            drive_reg <= drive_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            func_lo_reg <= pfm_pkg::RST_FUNC_LO;                             // R19
            func_hi_reg <= pfm_pkg::RST_FUNC_HI;                             // R19
        end else begin
            func_lo_reg <= func_lo_next;
            func_hi_reg <= func_hi_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            route_reg <= pfm_pkg::RST_IN_ROUTE;                              // R19
        end else begin
            route_reg <= route_next;
        end
    end

    // Read data, forwarding a write still in its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (accept && !hwrite) begin
            unique case (haddr[11:2])
                pfm_pkg::OFF_DRIVE[11:2]:    hrdata_reg <= {24'h00_0000, drive_next};   // R4
                pfm_pkg::OFF_FUNC_LO[11:2]:  hrdata_reg <= {24'h00_0000, func_lo_next}; // R5
                pfm_pkg::OFF_FUNC_HI[11:2]:  hrdata_reg <= {24'h00_0000, func_hi_next}; // R5
                pfm_pkg::OFF_IN_ROUTE[11:2]: hrdata_reg <= {24'h00_0000, route_next};
                default:                     hrdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Drive level selects
    assign portg_upper_drive_bit = drive_reg[pfm_pkg::DRV_PG_HI];           // R1
    assign portg_lower_drive_bit = drive_reg[pfm_pkg::DRV_PG_LO];           // R1
    assign portf_upper_drive_bit = drive_reg[pfm_pkg::DRV_PF_HI];           // R2
    assign portf_lower_drive_bit = drive_reg[pfm_pkg::DRV_PF_LO];           // R2
    assign porte_low_drive_bit   = drive_reg[pfm_pkg::DRV_PE_LO];           // R3

    // Function decode
    assign sel.func_lo = func_lo_reg;
    assign sel.func_hi = func_hi_reg;

    pfm_pin_decode u_decode (
        .sel (sel)
    );

    // Pin input synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_meta_reg   <= 8'h00;
            pa_sync_reg   <= 8'h00;
            capd_meta_reg <= 4'h0;
            capd_sync_reg <= 4'h0;
            capa_meta_reg <= 4'h0;
            capa_sync_reg <= 4'h0;
        end else begin
            pa_meta_reg   <= pa_in;
            pa_sync_reg   <= pa_meta_reg;
            capd_meta_reg <= cap_dflt_pin_in;
            capd_sync_reg <= capd_meta_reg;
            capa_meta_reg <= cap_alt_pin_in;
            capa_sync_reg <= capa_meta_reg;
        end
    end

    // Shared digital inputs only pass while the pin is an input
    assign pa_din     = pa_sync_reg & ~gpio_pa_oe;                          // R16
    assign gpio_pa_in = pa_sync_reg;

    // Output side mux
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pa_out[i]    = gpio_pa_out[i];
            pa_oe[i]     = gpio_pa_oe[i];
            pa_ana_en[i] = 1'b0;
            unique case (sel.fn[i])
                pfm_pkg::FN_GPIO: begin
                end
                pfm_pkg::FN_SER_CLK: begin
                    pa_out[i] = serial_clock_alt_out;                        // R6
                    pa_oe[i]  = serial_clock_alt_oe;
                end
                pfm_pkg::FN_SER_DIN: begin
                    pa_out[i] = 1'b0;                                        // R7
                    pa_oe[i]  = 1'b0;
                end
                pfm_pkg::FN_SER_DOUT: begin
                    pa_out[i] = serial_dout_alt;                             // R8
                    pa_oe[i]  = 1'b1;
                end
                pfm_pkg::FN_SER_SEL: begin
                    pa_out[i] = serial_select_alt_out;                       // R11
                    pa_oe[i]  = serial_select_alt_oe;
                end
                pfm_pkg::FN_STM_OUT: begin
                    pa_out[i] = std_timer_output;                            // R11
                    pa_oe[i]  = 1'b1;
                end
                pfm_pkg::FN_PTM0_OUT: begin
                    pa_out[i] = periodic_timer0_output;                      // R10
                    pa_oe[i]  = 1'b1;
                end
                pfm_pkg::FN_CMP_ANA: begin
                    pa_out[i]    = 1'b0;                                     // R6 R7 R9 R10
                    pa_oe[i]     = 1'b0;
                    pa_ana_en[i] = 1'b1;
                end
                pfm_pkg::FN_CMP_OUT: begin
                    pa_out[i] = (i == 1) ? comp0_out : comp1_out;            // R8 R11
                    pa_oe[i]  = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Input side routing to peripherals
    assign serial_clock_alt_in  = (sel.fn[3] == pfm_pkg::FN_SER_CLK) && pa_sync_reg[3]; // R6
    assign serial_din_alt       = (sel.fn[2] == pfm_pkg::FN_SER_DIN) && pa_sync_reg[2]; // R7
    assign serial_select_alt_in = (sel.fn[4] == pfm_pkg::FN_SER_SEL) && pa_sync_reg[4]; // R11
    assign std_timer_clock_in   = (sel.fn[6] == pfm_pkg::FN_GPIO) && pa_din[6];     // R9 R16

    // Default capture sources: PA4, PA5 while plain I/O, else low; the other two from other ports
    assign cap_dflt[pfm_pkg::RT_STD] = (sel.fn[4] == pfm_pkg::FN_GPIO) && pa_din[4];  // R11
    assign cap_dflt[pfm_pkg::RT_PT0] = (sel.fn[5] == pfm_pkg::FN_GPIO) && pa_din[5];  // R10
    assign cap_dflt[pfm_pkg::RT_PT1] = capd_sync_reg[pfm_pkg::RT_PT1];
    assign cap_dflt[pfm_pkg::RT_PT2] = capd_sync_reg[pfm_pkg::RT_PT2];
    assign timer_capture_in = (route_reg[3:0] & capa_sync_reg)
                            | (~route_reg[3:0] & cap_dflt);                 // R12

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_pg_drive;
        wr_hit(wr_pend_reg, addr_reg, pfm_pkg::OFF_DRIVE)
            |=> portg_upper_drive_bit == $past(hwdata[5]) && portg_lower_drive_bit == $past(hwdata[4]);
    endproperty
    a_pg_drive: assert property (p_pg_drive) else $error("port G drive wrong"); // R1

    property p_pf_drive;
        wr_hit(wr_pend_reg, addr_reg, pfm_pkg::OFF_DRIVE)
            |=> portf_upper_drive_bit == (HAS_PORT_F && $past(hwdata[3]))
                && portf_lower_drive_bit == (HAS_PORT_F && $past(hwdata[2]));
    endproperty
    a_pf_drive: assert property (p_pf_drive) else $error("port F drive wrong"); // R2

    property p_pe_drive;
        wr_hit(wr_pend_reg, addr_reg, pfm_pkg::OFF_DRIVE) ##1 !wr_pend_reg
            |-> porte_low_drive_bit == $past(hwdata[0]);
    endproperty
    a_pe_drive: assert property (p_pe_drive) else $error("port E drive wrong"); // R3

    property p_drive_rsvd;
        accept && !hwrite && haddr[11:2] == pfm_pkg::OFF_DRIVE[11:2]
            |=> hrdata[7:6] == 2'h0 && hrdata[1] == 1'b0 && hrdata[31:8] == 24'h00_0000;
    endproperty
    a_drive_rsvd: assert property (p_drive_rsvd) else $error("drive reserved set"); // R4

    property p_func_rsvd;
        func_lo_reg[1:0] == 2'h0 && func_hi_reg[7:6] == 2'h0;
    endproperty
    a_func_rsvd: assert property (p_func_rsvd) else $error("function reserved set"); // R5

    property p_pa3;
        func_lo_reg[7:6] == pfm_pkg::CODE_11 |-> pa_ana_en[3] && !pa_oe[3];
    endproperty
    a_pa3: assert property (p_pa3) else $error("PA3 comparator not selected"); // R6

    property p_pa2;
        func_lo_reg[5:4] == pfm_pkg::CODE_10 && $stable(func_lo_reg) && !pa_oe[2]
            |-> serial_din_alt == pa_sync_reg[2];
    endproperty
    a_pa2: assert property (p_pa2) else $error("PA2 serial data in wrong"); // R7

    property p_pa1;
        func_lo_reg[3:2] == pfm_pkg::CODE_10 |-> pa_oe[1] && pa_out[1] == serial_dout_alt;
    endproperty
    a_pa1: assert property (p_pa1) else $error("PA1 serial data out wrong"); // R8

    property p_pa6;
        func_hi_reg[5:4] != pfm_pkg::CODE_11 |-> !pa_ana_en[6]
            && std_timer_clock_in == (pa_sync_reg[6] && !gpio_pa_oe[6]);
    endproperty
    a_pa6: assert property (p_pa6) else $error("PA6 timer clock wrong"); // R9 R16

    property p_pa5;
        func_hi_reg[3:2] == pfm_pkg::CODE_10 |-> pa_oe[5] && pa_out[5] == periodic_timer0_output;
    endproperty
    a_pa5: assert property (p_pa5) else $error("PA5 timer output wrong"); // R10

    property p_pa4;
        func_hi_reg[1:0] == pfm_pkg::CODE_01 |-> pa_out[4] == serial_select_alt_out
            && pa_oe[4] == serial_select_alt_oe && !pa_ana_en[4];
    endproperty
    a_pa4: assert property (p_pa4) else $error("PA4 select wrong"); // R11

    property p_route;
        route_reg[pfm_pkg::RT_PT1] |-> timer_capture_in[pfm_pkg::RT_PT1]
            == capa_sync_reg[pfm_pkg::RT_PT1];
    endproperty
    a_route: assert property (p_route) else $error("capture route wrong"); // R12

    property p_apply;
        wr_hit(wr_pend_reg, addr_reg, pfm_pkg::OFF_FUNC_HI) && hwdata[5:4] == pfm_pkg::CODE_11
            |=> pa_ana_en[6] && !pa_oe[6];
    endproperty
    a_apply: assert property (p_apply) else $error("selection not applied"); // R18

    property p_reset_zero;
        !$past(hresetn) |-> drive_reg == 8'h00 && func_lo_reg == 8'h00
            && func_hi_reg == 8'h00 && route_reg == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset"); // R19

endmodule : pfm_top

// ==== rtl/pfm_pkg.sv ====
// Purpose: Constants and types for the port A pin function and drive select block
// Assumes: AHB-Lite register port, 32-bit data, one register per aligned word
// Notes:   Offsets are byte addresses within the block's 4 KB window
package pfm_pkg;

    // Register offsets (byte addresses)
    localparam logic [11:0] OFF_DRIVE    = 12'h000;
    localparam logic [11:0] OFF_FUNC_LO  = 12'h004;
    localparam logic [11:0] OFF_FUNC_HI  = 12'h008;
    localparam logic [11:0] OFF_IN_ROUTE = 12'h00c;

    // Reset values
    localparam logic [7:0] RST_DRIVE    = 8'h00;
    localparam logic [7:0] RST_FUNC_LO  = 8'h00;
    localparam logic [7:0] RST_FUNC_HI  = 8'h00;
    localparam logic [7:0] RST_IN_ROUTE = 8'h00;

    // Implemented bits
    localparam logic [7:0] MASK_DRIVE_FULL  = 8'h3d;
    localparam logic [7:0] MASK_DRIVE_SMALL = 8'h31;
    localparam logic [7:0] MASK_FUNC_LO     = 8'hfc;
    localparam logic [7:0] MASK_FUNC_HI     = 8'h3f;
    localparam logic [7:0] MASK_IN_ROUTE    = 8'h0f;

    // Drive register bit positions
    localparam int DRV_PG_HI = 5;
    localparam int DRV_PG_LO = 4;
    localparam int DRV_PF_HI = 3;
    localparam int DRV_PF_LO = 2;
    localparam int DRV_PE_LO = 0;

    // Function field low bit positions
    localparam int FLD_PA3 = 6;
    localparam int FLD_PA2 = 4;
    localparam int FLD_PA1 = 2;
    localparam int FLD_PA6 = 4;
    localparam int FLD_PA5 = 2;
    localparam int FLD_PA4 = 0;

    // Input route bit positions
    localparam int RT_STD  = 0;
    localparam int RT_PT0  = 1;
    localparam int RT_PT1  = 2;
    localparam int RT_PT2  = 3;

    // Function field codes
    localparam logic [1:0] CODE_01 = 2'h1;
    localparam logic [1:0] CODE_10 = 2'h2;
    localparam logic [1:0] CODE_11 = 2'h3;

    typedef enum logic [3:0] {
        FN_GPIO     = 4'h0,
        FN_SER_CLK  = 4'h1,
        FN_SER_DIN  = 4'h2,
        FN_SER_DOUT = 4'h3,
        FN_SER_SEL  = 4'h4,
        FN_STM_OUT  = 4'h5,
        FN_PTM0_OUT = 4'h6,
        FN_CMP_ANA  = 4'h7,
        FN_CMP_OUT  = 4'h8
    } pfm_fn_t;

endpackage : pfm_pkg

// ==== rtl/pfm_sel_if.sv ====
// Purpose: Carries function fields and decoded pin functions between modules
// Assumes: Combinational decode, no clock inside
// Notes:   Pins 0 and 7 always decode as plain I/O
`timescale 1ns/1ps
interface pfm_sel_if;
    logic [7:0]                   func_lo;
    logic [7:0]                   func_hi;
    pfm_pkg::pfm_fn_t [7:0]       fn;

    modport regs (output func_lo, output func_hi, input fn);
    modport dec  (input func_lo, input func_hi, output fn);
endinterface : pfm_sel_if

// ==== rtl/pfm_pin_decode.sv ====
// Purpose: Decode port A function fields into one function per pin
// Assumes: Fields already masked to implemented bits
// Notes:   Pure combinational; follows the registers with no delay
`timescale 1ns/1ps
module pfm_pin_decode (
    // Selection carrier
    pfm_sel_if.dec sel
);

    function automatic pfm_pkg::pfm_fn_t decode_field(
        input logic [1:0]       code,
        input pfm_pkg::pfm_fn_t fn01,
        input pfm_pkg::pfm_fn_t fn10,
        input pfm_pkg::pfm_fn_t fn11
    );
        pfm_pkg::pfm_fn_t r;
        r = pfm_pkg::FN_GPIO;
        if (code == pfm_pkg::CODE_01) begin
            r = fn01;
        end else if (code == pfm_pkg::CODE_10) begin
            r = fn10;
        end else if (code == pfm_pkg::CODE_11) begin
            r = fn11;
        end
        return r;
    endfunction : decode_field

    always_comb begin
        sel.fn[0] = pfm_pkg::FN_GPIO;
        sel.fn[7] = pfm_pkg::FN_GPIO;
        sel.fn[1] = decode_field(sel.func_lo[pfm_pkg::FLD_PA1 +: 2], pfm_pkg::FN_GPIO,
                                 pfm_pkg::FN_SER_DOUT, pfm_pkg::FN_CMP_OUT);   // R8 R18
        sel.fn[2] = decode_field(sel.func_lo[pfm_pkg::FLD_PA2 +: 2], pfm_pkg::FN_GPIO,
                                 pfm_pkg::FN_SER_DIN, pfm_pkg::FN_CMP_ANA);    // R7 R18
        sel.fn[3] = decode_field(sel.func_lo[pfm_pkg::FLD_PA3 +: 2], pfm_pkg::FN_GPIO,
                                 pfm_pkg::FN_SER_CLK, pfm_pkg::FN_CMP_ANA);    // R6 R18
        sel.fn[4] = decode_field(sel.func_hi[pfm_pkg::FLD_PA4 +: 2], pfm_pkg::FN_SER_SEL,
                                 pfm_pkg::FN_STM_OUT, pfm_pkg::FN_CMP_OUT);    // R11 R18
        sel.fn[5] = decode_field(sel.func_hi[pfm_pkg::FLD_PA5 +: 2], pfm_pkg::FN_GPIO,
                                 pfm_pkg::FN_PTM0_OUT, pfm_pkg::FN_CMP_ANA);   // R10 R18
        sel.fn[6] = decode_field(sel.func_hi[pfm_pkg::FLD_PA6 +: 2], pfm_pkg::FN_GPIO,
                                 pfm_pkg::FN_GPIO, pfm_pkg::FN_CMP_ANA);       // R9 R18
    end

endmodule : pfm_pin_decode

// ==== bench/pfm_testbench.sv ====
// Purpose: Self-checking bench for the port A pin function and drive select block
// Assumes: One AHB-Lite master in the bench, hready fed back from the slave
// Notes:   Random stimulus from a fixed seed; the model keeps masked register copies
`timescale 1ns/1ps
module testbench;
    // Bus
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r, d;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    // Pins and peripherals
    logic [7:0]  pa_in, pa_out, pa_oe, pa_ana_en, gpio_pa_out, gpio_pa_oe, gpio_pa_in;
    logic        serial_clock_alt_out, serial_clock_alt_oe, serial_clock_alt_in;
    logic        serial_din_alt, serial_dout_alt, serial_select_alt_out;
    logic        serial_select_alt_oe, serial_select_alt_in, std_timer_output;
    logic        periodic_timer0_output, std_timer_clock_in, comp0_out, comp1_out;
    logic [3:0]  timer_capture_in, cap_dflt_pin_in, cap_alt_pin_in;
    logic        portg_upper_drive_bit, portg_lower_drive_bit, portf_upper_drive_bit;
    logic        portf_lower_drive_bit, porte_low_drive_bit;
    // Model state
    logic [16:0] pv;
    logic [7:0]  m_reg [4];
    logic [11:0] offs [4] = '{pfm_pkg::OFF_DRIVE, pfm_pkg::OFF_FUNC_LO,
                              pfm_pkg::OFF_FUNC_HI, pfm_pkg::OFF_IN_ROUTE};
    logic [7:0]  msk [4]  = '{pfm_pkg::MASK_DRIVE_FULL, pfm_pkg::MASK_FUNC_LO,
                              pfm_pkg::MASK_FUNC_HI, pfm_pkg::MASK_IN_ROUTE};
    int          err_count = 0;
    int          num_checks = 0;

    assign hready = hreadyout;
    assign {serial_clock_alt_out, serial_clock_alt_oe, serial_dout_alt, serial_select_alt_out,
            serial_select_alt_oe, std_timer_output, periodic_timer0_output, comp0_out,
            comp1_out, cap_dflt_pin_in, cap_alt_pin_in} = pv;

    pfm_top #(.HAS_PORT_F(1'b1)) dut_u (.*);

    always #12.5 hclk = ~hclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One single word transfer; read data lands in r
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic check_out();
        logic [7:0] eo, eoe, ea;
        logic [1:0] c;
        eo = gpio_pa_out;
        eoe = gpio_pa_oe;
        ea = 8'h00;
        for (int p = 1; p < 7; p++) begin
            c = (p < 4) ? m_reg[1][2*p +: 2] : m_reg[2][2*p-8 +: 2];
            if (c == 2'h3 && p != 1 && p != 4) begin
                {eo[p], eoe[p], ea[p]} = 3'b001;
            end else if (c == 2'h3) begin
                {eo[p], eoe[p]} = {(p == 1) ? comp0_out : comp1_out, 1'b1};
            end else if (c == 2'h2) begin
                case (p)
                    1: {eo[p], eoe[p]} = {serial_dout_alt, 1'b1};
                    2: {eo[p], eoe[p]} = 2'b00;
                    3: {eo[p], eoe[p]} = {serial_clock_alt_out, serial_clock_alt_oe};
                    4: {eo[p], eoe[p]} = {std_timer_output, 1'b1};
                    5: {eo[p], eoe[p]} = {periodic_timer0_output, 1'b1};
                    default: ;
                endcase
            end else if (c == 2'h1 && p == 4) begin
                {eo[p], eoe[p]} = {serial_select_alt_out, serial_select_alt_oe};
            end
        end
        chk({pa_out, pa_oe, pa_ana_en}, {eo, eoe, ea});
        chk({portg_upper_drive_bit, portg_lower_drive_bit, portf_upper_drive_bit,
             portf_lower_drive_bit, porte_low_drive_bit}, {m_reg[0][5:2], m_reg[0][0]});
    endtask : check_out

    task automatic check_in();
        logic [1:0] c2, c3, c4, c5, c6;
        logic [3:0] cap;
        logic [2:0] ser;
        {c3, c2} = m_reg[1][7:4];
        {c6, c5, c4} = m_reg[2][5:0];
        cap[0] = m_reg[3][0] ? cap_alt_pin_in[0] : (c4 == 2'h0 && !gpio_pa_oe[4] && pa_in[4]);
        cap[1] = m_reg[3][1] ? cap_alt_pin_in[1] : (c5 < 2'h2 && !gpio_pa_oe[5] && pa_in[5]);
        cap[3:2] = (m_reg[3][3:2] & cap_alt_pin_in[3:2]) | (~m_reg[3][3:2] & cap_dflt_pin_in[3:2]);
        ser = {c3 == 2'h2 && pa_in[3], c2 == 2'h2 && pa_in[2], c4 == 2'h1 && pa_in[4]};
        chk({28'h0, timer_capture_in}, {28'h0, cap});
        chk({31'h0, std_timer_clock_in}, {31'h0, c6 != 2'h3 && !gpio_pa_oe[6] && pa_in[6]});
        chk({serial_clock_alt_in, serial_din_alt, serial_select_alt_in}, ser);
        chk({24'h0, gpio_pa_in}, {24'h0, pa_in});
    endtask : check_in

    task automatic final_report();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {pa_in, gpio_pa_out, gpio_pa_oe, pv} = '0;
        m_reg = '{default: 8'h00};
        void'($urandom(18547));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        #1 check_out();
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, offs[i], 32'h0);
            chk(r, 32'h0);
        end
        for (int n = 0; n < 40; n++) begin
            for (int i = 0; i < 4; i++) begin
                d = $urandom;
                bus(1'b1, offs[i], d);
                m_reg[i] = d[7:0] & msk[i];
                #1 check_out();
            end
            for (int i = 0; i < 4; i++) begin
                bus(1'b0, offs[i], 32'h0);
                chk(r, {24'h0, m_reg[i]});
            end
            bus(1'b0, 12'h010, 32'h0);
            chk({r[31:1], r[0] | hresp}, 32'h0);
            d = $urandom;
            pa_in <= d[7:0];
            gpio_pa_out <= d[15:8];
            gpio_pa_oe <= d[23:16];
            d = $urandom;
            pv <= d[16:0];
            repeat (3) @(posedge hclk);
            #1 check_in();
            check_out();
        end
        // Timer capture on the alternate pin, peripheral idle while selecting
        @(posedge hclk);
        pv <= '0;
        gpio_pa_oe <= 8'h00;
        bus(1'b1, pfm_pkg::OFF_FUNC_HI, 32'h0000_0008);
        m_reg[2] = 8'h08;
        bus(1'b1, pfm_pkg::OFF_IN_ROUTE, 32'h0000_0002);
        m_reg[3] = 8'h02;
        pv <= 17'h0_0402;
        repeat (3) @(posedge hclk);
        #1 check_in();
        check_out();
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        m_reg = '{default: 8'h00};
        #1 check_out();
        final_report();
    end

    // Hang guard, well beyond the roughly 1200 cycles the tests need
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        final_report();
    end
endmodule : testbench
